// >>> mtwi_bus_slave.sv
// behavioural bus slave that acknowledges every byte and may stretch the clock
`timescale 1ns/1ps
module mtwi_bus_slave (
    input wire logic scl,
    input wire logic sda,
    input wire logic slow,
    output logic sda_pull,
    output logic scl_pull,
    output logic [7:0] last_byte,
    output logic [7:0] byte_cnt
);
    logic [7:0] sh;
    int n;
    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        last_byte = 8'h00;
        byte_cnt = 8'h00;
        sh = 8'h00;
        n = 0;
    end
    // start or stop restarts framing, first byte is the address
    always @(sda) if (scl === 1'b1) n = 0;
    always @(posedge scl) if (n < 8) begin
        sh = {sh[6:0], sda};
        n = n + 1;
    end
    always @(negedge scl) begin
        if (n == 8) begin
            sda_pull = 1'b1;
            last_byte = sh;
            byte_cnt = byte_cnt + 8'h01;
            n = 9;
        end else if (n == 9) begin
            sda_pull = 1'b0;
            n = 0;
            if (slow) begin
                scl_pull = 1'b1;
                #2000 scl_pull = 1'b0;
            end
        end
    end
endmodule

// >>> mtwi_core.sv
// multimaster two-wire bus interface with register port
`timescale 1ns/1ps
module mtwi_core (
    input wire logic clk,
    input wire logic rst_b,
    input wire mtwi_pkg::mtwi_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    output logic serial_clock_out,
    output logic serial_clock_oe_b,
    output logic serial_data_out,
    output logic serial_data_oe_b,
    output logic irq
);
    import mtwi_pkg::*;

    mtwi_state_t q;
    mtwi_state_t n;
    logic [7:0] nb;
    logic [8:0] half;
    logic rise;
    logic fall;
    logic bit_fall;
    logic start_det;
    logic stop_det;
    logic event_flag;
    logic evc;
    logic hdr;
    logic pend;

    function automatic logic is_acc(input mtwi_req_t r, input logic [2:0] a);
        return (r.we | r.re) && r.addr == a;
    endfunction

    assign nb = {q.sh[6:0], q.rbit};
    // half bit time depends on speed mode and divider
    assign half = q.ccr[CCR_FAST] ? FAST_MIN_HALF + {2'b00, q.ccr[6:0]}
                                  : STD_MIN_HALF + {1'b0, q.ccr[6:0], 1'b0};
    assign rise = serial_clock_pin & ~q.scl_q;
    assign fall = ~serial_clock_pin & q.scl_q;
    // a slave ignores the clock fall that follows a start, no bit was sampled yet
    assign bit_fall = fall & (q.msl | q.ph);
    assign start_det = serial_clock_pin & q.scl_q & q.sda_q & ~serial_data_pin;
    assign stop_det = serial_clock_pin & q.scl_q & ~q.sda_q & serial_data_pin;
    assign event_flag = q.sb | q.btf | q.address_matched_flag | q.aev | q.af | q.stopf
                        | q.arlo | q.misplaced_condition_error;
    assign evc = q.sr1_seen & (is_acc(reg_req, MTWI_DR) | (reg_req.we && reg_req.addr == MTWI_CR));
    assign hdr = nb[7:3] == MTWI_HDR10 && nb[2:1] == q.oar2[OAR2_HI+:2];
    assign pend = q.sb | q.btf | q.address_matched_flag | q.aev;

    always_comb begin
        n = q;
        n.scl_q = serial_clock_pin;
        n.sda_q = serial_data_pin;
        n.rdata = 8'h00;
        n.tmr = (q.tmr == 9'h000) ? q.tmr : q.tmr - 9'h001;
        if (reg_req.re) begin
            unique case (reg_req.addr)
                MTWI_CR: begin
                    n.rdata[CR_PE] = q.pe;
                    n.rdata[CR_ENGC] = q.engc;
                    n.rdata[CR_START] = q.start;
                    n.rdata[CR_ACK] = q.ack_en;
                    n.rdata[CR_STOP] = q.stop;
                    n.rdata[CR_IRQ_EN] = q.event_interrupt_enable;
                end
                MTWI_SR1: begin
                    n.rdata[SR1_EVENT] = event_flag;
                    n.rdata[SR1_MATCHED] = q.address_matched_flag;
                    n.rdata[SR1_TRA] = q.tra;
                    n.rdata[SR1_BUSY] = q.busy;
                    n.rdata[SR1_BTF] = q.btf;
                    n.rdata[SR1_AEV] = q.aev;
                    n.rdata[SR1_MSL] = q.msl;
                    n.rdata[SR1_SB] = q.sb;
                    n.sr1_seen = 1'b1;
                end
                MTWI_SR2: begin
                    n.rdata[SR2_AF] = q.af;
                    n.rdata[SR2_STOPF] = q.stopf;
                    n.rdata[SR2_ARLO] = q.arlo;
                    n.rdata[SR2_MISPLACED] = q.misplaced_condition_error;
                    n.rdata[SR2_GCAL] = q.gcal;
                    n.af = 1'b0;
                    n.stopf = 1'b0;
                    n.arlo = 1'b0;
                    n.misplaced_condition_error = 1'b0;
                    n.gcal = 1'b0;
                end
                MTWI_CCR: n.rdata = q.ccr;
                MTWI_OAR1: n.rdata = q.oar1;
                MTWI_OAR2: n.rdata = q.oar2;
                MTWI_DR: begin
                    n.rdata = q.dr;
                    n.dr_full = 1'b0;
                end
                default: n.rdata = 8'h00;
            endcase
        end
        if (reg_req.we) begin
            unique case (reg_req.addr)
                MTWI_CR: begin
                    n.pe = reg_req.wdata[CR_PE];
                    n.engc = reg_req.wdata[CR_ENGC];
                    n.start = reg_req.wdata[CR_START];
                    n.ack_en = reg_req.wdata[CR_ACK];
                    n.stop = reg_req.wdata[CR_STOP];
                    n.event_interrupt_enable = reg_req.wdata[CR_IRQ_EN];
                end
                MTWI_CCR: n.ccr = reg_req.wdata;
                MTWI_OAR1: n.oar1 = reg_req.wdata;
                MTWI_OAR2: n.oar2 = reg_req.wdata;
                MTWI_DR: begin
                    n.dr = reg_req.wdata;
                    n.dr_full = 1'b1;
                end
                default: ;
            endcase
        end
        // status read then data access or control register write releases the byte handshake
        if (evc) begin
            n.sb = 1'b0;
            n.btf = 1'b0;
            n.address_matched_flag = 1'b0;
            n.aev = 1'b0;
            n.sr1_seen = 1'b0;
        end
        unique case (q.st)
            ST_IDLE: begin
                if (q.pe && q.start && !q.busy) begin
                    n.st = ST_MSTART;
                    n.msl = 1'b1;
                    n.sda_low = 1'b1;
                    n.tmr = half;
                end
            end
            ST_MSTART: begin
                if (q.tmr == 9'h000) begin
                    n.scl_low = 1'b1;
                    n.sb = 1'b1;
                    n.start = 1'b0;
                    n.tra = 1'b1;
                    n.addr_phase = 1'b1;
                    n.busy = 1'b1;
                    n.st = ST_HOLD;
                end
            end
            ST_MSTOP, ST_MRESTART: begin
                if (!q.ph) begin
                    if (q.tmr == 9'h000) begin
                        n.scl_low = 1'b0;
                        n.ph = 1'b1;
                        n.tmr = half;
                    end
                end else if (!serial_clock_pin) begin
                    n.tmr = half;
                end else if (q.tmr == 9'h000) begin
                    n.ph = 1'b0;
                    if (q.st == ST_MSTOP) begin
                        n.sda_low = 1'b0;
                        n.msl = 1'b0;
                        n.stop = 1'b0;
                        n.addressed = 1'b0;
                        n.st = ST_IDLE;
                    end else begin
                        n.sda_low = 1'b1;
                        n.tmr = half;
                        n.st = ST_MSTART;
                    end
                end
            end
            ST_HOLD: begin
                n.scl_low = 1'b1;
                if (!pend) begin
                    n.ph = 1'b0;
                    n.tmr = half;
                    n.cnt = 4'h0;
                    if (q.msl && q.stop) begin
                        n.sda_low = 1'b1;
                        n.st = ST_MSTOP;
                    end else if (q.msl && q.start) begin
                        n.sda_low = 1'b0;
                        n.st = ST_MRESTART;
                    end else if (!q.tra || q.dr_full) begin
                        n.st = ST_XFER;
                        n.sh = q.dr;
                        n.sda_low = q.tra & ~q.dr[7];
                        if (q.tra) begin
                            n.dr_full = 1'b0;
                        end
                        if (!q.msl) begin
                            n.scl_low = 1'b0;
                        end
                    end
                end
            end
            ST_XFER: begin
                if (q.msl) begin
                    if (!q.ph) begin
                        if (q.tmr == 9'h000) begin
                            n.scl_low = 1'b0;
                            n.ph = 1'b1;
                            n.tmr = half;
                        end
                    end else if (!serial_clock_pin) begin
                        n.tmr = half;
                    end else if (q.tmr == 9'h000) begin
                        n.scl_low = 1'b1;
                        n.ph = 1'b0;
                        n.tmr = half;
                    end
                end
                if (rise) begin
                    n.rbit = serial_data_pin;
                end
                if (!q.msl && (rise || fall)) begin
                    n.ph = rise;
                end
                if (rise && q.msl && q.tra && q.cnt != MTWI_ACK_BIT && q.sh[7]
                    && !serial_data_pin) begin
                    n.arlo = 1'b1;
                    n.msl = 1'b0;
                    n.sda_low = 1'b0;
                    n.scl_low = 1'b0;
                    n.st = ST_IDLE;
                end else if (bit_fall && q.cnt == MTWI_ACK_BIT) begin
                    n.cnt = 4'h0;
                    n.sda_low = 1'b0;
                    if (!q.msl && !q.addressed) begin
                        if (q.hit) begin
                            n.addressed = 1'b1;
                            n.address_matched_flag = 1'b1;
                            n.hit = 1'b0;
                            n.scl_low = 1'b1;
                            n.st = ST_HOLD;
                        end else if (!q.second) begin
                            n.st = ST_IDLE;
                        end
                    end else if (q.tra && q.rbit) begin
                        n.af = 1'b1;
                        if (q.msl) begin
                            n.btf = 1'b1;
                            n.st = ST_HOLD;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end else begin
                        if (q.msl && q.addr_phase) begin
                            n.aev = 1'b1;
                            n.addr_phase = 1'b0;
                            n.tra = ~q.sh[0];
                        end else begin
                            n.btf = 1'b1;
                        end
                        n.scl_low = 1'b1;
                        n.st = ST_HOLD;
                    end
                end else if (bit_fall) begin
                    n.sh = nb;
                    n.cnt = q.cnt + 4'h1;
                    n.sda_low = q.tra & ~nb[7];
                    if (q.cnt == MTWI_LAST_BIT) begin
                        n.sda_low = 1'b0;
                        if (!q.tra && (q.msl || q.addressed)) begin
                            n.dr = nb;
                            n.sda_low = q.ack_en;
                        end else if (!q.tra) begin
                            n.dr = nb;
                            n.gcal = 1'b0;
                            if (q.oar2[OAR2_A10]) begin
                                n.hit = (q.second && nb == q.oar1)
                                        || (!q.second && hdr && nb[0] && q.hdr_ok);
                                n.second = !q.second && hdr && !nb[0];
                                n.hdr_ok = q.hdr_ok | (q.second && nb == q.oar1);
                                n.tra = !q.second && nb[0];
                            end else begin
                                n.gcal = q.engc && nb == MTWI_GC_ADDR;
                                n.hit = nb[7:1] == q.oar1[7:1] || n.gcal;
                                n.tra = nb[0] && !n.gcal;
                            end
                            n.sda_low = q.ack_en & (n.hit | n.second);
                        end
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        if (start_det) begin
            n.busy = 1'b1;
            if (q.st == ST_XFER && (q.cnt != 4'h0 || q.msl)) begin
                n.misplaced_condition_error = 1'b1;
            end
            if (!q.msl || q.st == ST_XFER) begin
                n.msl = 1'b0;
                n.st = ST_XFER;
                n.ph = 1'b0;
                n.cnt = 4'h0;
                n.addressed = 1'b0;
                n.tra = 1'b0;
                n.hit = 1'b0;
                n.second = 1'b0;
                n.sda_low = 1'b0;
                n.scl_low = 1'b0;
            end
        end
        if (stop_det) begin
            n.busy = 1'b0;
            n.hdr_ok = 1'b0;
            if (q.st != ST_MSTOP) begin
                if (q.st == ST_XFER && q.cnt != 4'h0) begin
                    n.misplaced_condition_error = 1'b1;
                end
                if (q.addressed && !q.msl) begin
                    n.stopf = 1'b1;
                end
                n.st = ST_IDLE;
                n.msl = 1'b0;
                n.addressed = 1'b0;
                n.sda_low = 1'b0;
                n.scl_low = 1'b0;
            end
        end
        if (!n.pe) begin
            n.st = ST_IDLE;
            n.msl = 1'b0;
            n.busy = 1'b0;
            n.start = 1'b0;
            n.stop = 1'b0;
            n.addressed = 1'b0;
            n.sda_low = 1'b0;
            n.scl_low = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= MTWI_RESET;
        end else begin
            q <= n;
        end
    end

    // pins only ever pulled low
    assign serial_clock_out = 1'b0;
    assign serial_data_out = 1'b0;
    assign serial_clock_oe_b = ~q.scl_low;
    assign serial_data_oe_b = ~q.sda_low;
    assign reg_rdata = q.rdata;
    assign irq = event_flag & q.event_interrupt_enable;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_slave_when_off;
        !q.pe |=> !q.msl && q.st == ST_IDLE;
    endproperty
    a_slave_when_off: assert property (p_slave_when_off) else $error("master while disabled");

    property p_start_req;
        q.st == ST_IDLE && q.pe && q.start && !q.busy && !start_det && !stop_det
            |=> q.msl && q.st == ST_MSTART;
    endproperty
    a_start_req: assert property (p_start_req) else $error("start request ignored");

    property p_arlo_slave;
        $rose(q.arlo) |-> !q.msl && serial_clock_oe_b && serial_data_oe_b;
    endproperty
    a_arlo_slave: assert property (p_arlo_slave) else $error("master after loss");

    property p_off_release;
        !q.pe |=> serial_clock_oe_b && serial_data_oe_b;
    endproperty
    a_off_release: assert property (p_off_release) else $error("pins driven when off");

    property p_hold_low;
        q.st == ST_HOLD |-> !serial_clock_oe_b;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("clock not stretched");

    property p_tx_wait;
        q.st == ST_HOLD && q.tra && !q.dr_full && !q.stop && !q.start && q.pe
            && !start_det && !stop_det |=> q.st == ST_HOLD;
    endproperty
    a_tx_wait: assert property (p_tx_wait) else $error("sent without data");

    property p_no_ack;
        q.st == ST_XFER && q.cnt == MTWI_ACK_BIT && !q.tra && !q.ack_en |-> serial_data_oe_b;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack driven while disabled");

    property p_misplaced_condition_error;
        start_det && q.pe && q.st == ST_XFER && !q.msl && q.cnt != 4'h0
            |=> q.misplaced_condition_error ##1 event_flag;
    endproperty
    a_misplaced_condition_error: assert property (p_misplaced_condition_error) else $error("misplaced start missed");

    property p_match_hold;
        $rose(q.address_matched_flag) |-> q.st == ST_HOLD && !serial_clock_oe_b && event_flag;
    endproperty
    a_match_hold: assert property (p_match_hold) else $error("match not held");

    property p_irq;
        $rose(q.btf) && q.event_interrupt_enable |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("byte event without interrupt");

    c_master_start: cover property (q.st == ST_MSTART ##[1:1000] q.sb);
    c_addr_match: cover property ($rose(q.address_matched_flag));
    c_misplaced_condition_error: cover property ($rose(q.misplaced_condition_error));
    c_master_stop: cover property (q.st == ST_MSTOP ##[1:1000] q.st == ST_IDLE);
endmodule

// >>> mtwi_pkg.sv
// constants, register map and state types of the two-wire bus interface
package mtwi_pkg;
    // register indices on the plain register port
    localparam logic [2:0] MTWI_CR = 3'h0;
    localparam logic [2:0] MTWI_SR1 = 3'h1;
    localparam logic [2:0] MTWI_SR2 = 3'h2;
    localparam logic [2:0] MTWI_CCR = 3'h3;
    localparam logic [2:0] MTWI_OAR1 = 3'h4;
    localparam logic [2:0] MTWI_OAR2 = 3'h5;
    localparam logic [2:0] MTWI_DR = 3'h6;
    // control register fields
    localparam int CR_PE = 5;
    localparam int CR_ENGC = 4;
    localparam int CR_START = 3;
    localparam int CR_ACK = 2;
    localparam int CR_STOP = 1;
    localparam int CR_IRQ_EN = 0;
    // status register 1 fields
    localparam int SR1_EVENT = 7;
    localparam int SR1_MATCHED = 6;
    localparam int SR1_TRA = 5;
    localparam int SR1_BUSY = 4;
    localparam int SR1_BTF = 3;
    localparam int SR1_AEV = 2;
    localparam int SR1_MSL = 1;
    localparam int SR1_SB = 0;
    // status register 2 fields
    localparam int SR2_AF = 4;
    localparam int SR2_STOPF = 3;
    localparam int SR2_ARLO = 2;
    localparam int SR2_MISPLACED = 1;
    localparam int SR2_GCAL = 0;
    // clock control and second address register fields
    localparam int CCR_FAST = 7;
    localparam int OAR2_A10 = 7;
    localparam int OAR2_HI = 1;
    // byte framing
    localparam logic [3:0] MTWI_LAST_BIT = 4'h7;
    localparam logic [3:0] MTWI_ACK_BIT = 4'h8;
    localparam logic [4:0] MTWI_HDR10 = 5'h1e;
    localparam logic [7:0] MTWI_GC_ADDR = 8'h00;
    // bit timing: half periods never shorter than the speed mode allows
    localparam int CLK_PERIOD_NS = 25;
    localparam int STD_HALF_NS = 5000;
    localparam int FAST_HALF_NS = 1250;
    localparam logic [8:0] STD_MIN_HALF = 9'((STD_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [8:0] FAST_MIN_HALF = 9'((FAST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {ST_IDLE, ST_XFER, ST_HOLD, ST_MSTART, ST_MSTOP, ST_MRESTART} mtwi_fsm_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } mtwi_req_t;

    typedef struct packed {
        mtwi_fsm_t st;
        logic ph;
        logic [8:0] tmr;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rbit;
        logic sda_low;
        logic scl_low;
        logic scl_q;
        logic sda_q;
        logic pe;
        logic engc;
        logic start;
        logic stop;
        logic ack_en;
        logic event_interrupt_enable;
        logic [7:0] ccr;
        logic [7:0] oar1;
        logic [7:0] oar2;
        logic [7:0] dr;
        logic dr_full;
        logic sb;
        logic btf;
        logic address_matched_flag;
        logic aev;
        logic af;
        logic stopf;
        logic arlo;
        logic misplaced_condition_error;
        logic gcal;
        logic msl;
        logic busy;
        logic tra;
        logic addressed;
        logic addr_phase;
        logic hdr_ok;
        logic second;
        logic hit;
        logic sr1_seen;
        logic [7:0] rdata;
    } mtwi_state_t;

    localparam mtwi_state_t MTWI_RESET = '0;
endpackage

// >>> test_multimaster_two_wire_interface.sv
// testbench: master transmit and slave address sequences against a bus slave model
`timescale 1ns/1ps
module test_multimaster_two_wire_interface;
    import mtwi_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic slow = 1'b0;
    mtwi_req_t req = '0;
    logic [7:0] rdata, last_byte, byte_cnt, a, d;
    logic scl_oe_b, sda_oe_b, irq, scl_pull, sda_pull, pend;
    logic scl_o, sda_o;
    logic m_scl = 1'b0;
    logic m_sda = 1'b0;
    logic [31:0] seed = 32'h09333542;
    logic [7:0] q_exp[$];
    logic [7:0] q_msk[$];
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    wire scl = scl_oe_b & ~scl_pull & ~m_scl;
    wire sda = sda_oe_b & ~sda_pull & ~m_sda;
    always #12.5 clk = ~clk;
    mtwi_core mtwi_core_i (.clk(clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
        .serial_clock_pin(scl), .serial_data_pin(sda), .serial_clock_out(scl_o),
        .serial_clock_oe_b(scl_oe_b), .serial_data_out(sda_o), .serial_data_oe_b(sda_oe_b),
        .irq(irq));
    mtwi_bus_slave mtwi_bus_slave_i (.scl(scl), .sda(sda), .slow(slow), .sda_pull(sda_pull),
        .scl_pull(scl_pull), .last_byte(last_byte), .byte_cnt(byte_cnt));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
        req <= '{addr: ad, wdata: wd, we: 1'b1, re: 1'b0};
        @(posedge clk);
    endtask
    // one bit from a bench-side bus master: data changes only while the clock is low
    task automatic mbit(input logic b);
        m_scl <= 1'b1;
        repeat (4) @(posedge clk);
        m_sda <= ~b;
        repeat (4) @(posedge clk);
        m_scl <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] ad, input logic [7:0] m, input logic [7:0] e);
        q_msk.push_back(m);
        q_exp.push_back(e);
        req <= '{addr: ad, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        req <= '0;
        @(negedge clk);
        while (irq !== 1'b1 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        check({7'h00, irq}, 8'h01);
        @(posedge clk);
    endtask
    // read data stand in the cycle after the strobe only
    always @(posedge clk) pend <= req.re;
    always @(negedge clk) if (pend === 1'b1) check(rdata & q_msk.pop_front(), q_exp.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({6'h00, scl_oe_b, sda_oe_b}, 8'h03);
        rd(3'h7, 8'hff, 8'h00);
        rd(MTWI_CR, 8'hff, 8'h00);
        wr(MTWI_CCR, 8'h80);
        wr(MTWI_CR, 8'h25);
        rd(MTWI_SR1, 8'h02, 8'h00);
        $display("test reset and idle done");
        wr(MTWI_CR, 8'h2d);
        wait_irq();
        rd(MTWI_SR1, 8'h93, 8'h93);
        seed = xs(seed);
        a = {seed[6:0], 1'b0};
        wr(MTWI_DR, a);
        wait_irq();
        check(last_byte, a);
        check({7'h00, scl_oe_b}, 8'h00);
        rd(MTWI_SR1, 8'ha6, 8'ha6);
        wr(MTWI_CR, 8'h25);
        req <= '0;
        slow <= 1'b1;
        seed = xs(seed);
        d = seed[7:0];
        repeat (200) @(posedge clk);
        check({7'h00, scl_oe_b}, 8'h00);
        wr(MTWI_DR, d);
        wait_irq();
        check(last_byte, d);
        check(byte_cnt, 8'h02);
        rd(MTWI_SR1, 8'h88, 8'h88);
        wr(MTWI_CR, 8'h27);
        req <= '0;
        repeat (600) @(posedge clk);
        rd(MTWI_SR1, 8'h12, 8'h00);
        req <= '0;
        @(posedge clk);
        check({6'h00, scl, sda}, 8'h03);
        $display("test master transmit done");
        slow <= 1'b0;
        seed = xs(seed);
        a = {seed[14:8], 1'b0};
        wr(MTWI_OAR1, a);
        req <= '0;
        m_sda <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 7; i >= 0; i--) mbit(a[i]);
        mbit(1'b1);
        check({7'h00, sda_oe_b}, 8'h00);
        m_scl <= 1'b1;
        wait_irq();
        check({7'h00, scl_oe_b}, 8'h00);
        rd(MTWI_SR1, 8'hf2, 8'hd0);
        rd(MTWI_DR, 8'hff, a);
        req <= '0;
        mbit(1'b1);
        mbit(1'b1);
        m_sda <= 1'b1;
        wait_irq();
        rd(MTWI_SR2, 8'h02, 8'h02);
        req <= '0;
        m_sda <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test slave address and misplaced start done");
        wr(MTWI_CR, 8'h00);
        req <= '0;
        repeat (2) @(posedge clk);
        check({6'h00, scl_oe_b, sda_oe_b}, 8'h03);
        check({7'h00, irq}, 8'h00);
        check({6'h00, scl_o, sda_o}, 8'h00);
        $display("test disable done");
        final_report();
    end
endmodule
